/* inc/opb_port_b_map.vh */
// opb_port_b_map.vh: register map, field positions, reset values and timing counts of the output port block.
// assumes a 100 MHz pclk and an APB master with 32-bit data.
`ifndef OPB_PORT_B_MAP_VH
`define OPB_PORT_B_MAP_VH

// ==========================================================================
// register byte offsets
`define OPB_OFS_PORT        12'h000
`define OPB_OFS_LATCHED     12'h004
`define OPB_OFS_PARALLEL_IO_CONTROL        12'h008
`define OPB_OFS_MODE        12'h00C
`define OPB_OFS_STATUS      12'h010

// ==========================================================================
// parallel_io_control fields
`define OPB_PARALLEL_IO_CONTROL_POL        0
`define OPB_PARALLEL_IO_CONTROL_EDGE       1
`define OPB_PARALLEL_IO_CONTROL_PLS        2
`define OPB_PARALLEL_IO_CONTROL_DIR        3
`define OPB_PARALLEL_IO_CONTROL_HANDSHAKE_SELECT_BIT       4
`define OPB_PARALLEL_IO_CONTROL_W          5
`define OPB_PARALLEL_IO_CONTROL_RST        5'h00

// mode and status fields
`define OPB_MODE_EXP        0
`define OPB_STAT_ACTIVE     0
`define OPB_STAT_START      1
`define OPB_STAT_WPEND      2

// ==========================================================================
// bus-cycle timing: one bus cycle is four pclk quarters
`define OPB_CLK_MHZ         100
`define OPB_BUS_CYCLE_NS    40
`define OPB_QUARTERS        ((`OPB_BUS_CYCLE_NS * `OPB_CLK_MHZ) / 4000)
`define OPB_Q_ELOW_A        2'h0
`define OPB_Q_ELOW_B        2'h1
`define OPB_Q_EHIGH_A       2'h2
`define OPB_Q_EHIGH_B       2'h3
// strobe length in full bus periods, and the counter value seen at the last one
`define OPB_STROBE_B_OUTPUT_PERIODS    2'h2
`define OPB_STROBE_B_OUTPUT_LAST       2'h1

// ==========================================================================
// reset values
`define OPB_PINS_RST        8'h00
`define OPB_DATA_RST        32'h0000_0000

`endif

/* rtl/opb_pin_sync.v */
// opb_pin_sync.v: three-flop synchroniser with agreement filter for pin inputs.
// assumes the inputs are asynchronous to pclk; the output moves only when stages two and three agree.
`timescale 1ns/1ns

module opb_pin_sync #(
  parameter W = 1
) (
  pclk,
  presetn,
  pin_in,
  sync_out
);
  input  wire         pclk;
  input  wire         presetn;
  input  wire [W-1:0] pin_in;
  output reg  [W-1:0] sync_out;

  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;

  // ========================================================================
  // synchroniser chain; s1 feeds s2 only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q     <= {W{1'b0}};
      s2_q     <= {W{1'b0}};
      s3_q     <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // a change counts only once two later stages agree, filtering metastable echoes
      if (s2_q == s3_q) begin
        sync_out <= s3_q;
      end
    end
  end

endmodule

/* rtl/opb_port_b.v */
// opb_port_b.v: eight-bit fixed-direction output port with its strobe pin, behind an APB slave.
// assumes one 100 MHz pclk, an asynchronous active-low reset and external bus pins that are asynchronous.
`timescale 1ns/1ns
`include "opb_port_b_map.vh"

module opb_port_b (
  pclk,
  presetn,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  output_port_data,
  strobe_b_output,
  strobe_a_input,
  address_latch_strobe,
  bus_addr_high,
  bus_read_write,
  ext_read_data,
  ext_access_req,
  ext_access_write,
  ext_write_data,
  port_read_strobe,
  bus_clock_e
);
  input  wire        pclk;
  input  wire        presetn;
  input  wire        psel;
  input  wire        penable;
  input  wire        pwrite;
  input  wire [11:0] paddr;
  input  wire [31:0] pwdata;
  output reg  [31:0] prdata;
  output wire        pready;
  output wire        pslverr;
  output reg  [7:0]  output_port_data;
  output reg         strobe_b_output;
  input  wire        strobe_a_input;
  input  wire        address_latch_strobe;
  input  wire [7:0]  bus_addr_high;
  input  wire        bus_read_write;
  input  wire [7:0]  ext_read_data;
  output reg         ext_access_req;
  output reg         ext_access_write;
  output reg  [7:0]  ext_write_data;
  output wire        port_read_strobe;
  output reg         bus_clock_e;

  // ========================================================================
  // pin synchronisers
  wire       as_s;
  wire       rw_s;
  wire       strobe_a_input_s;
  wire [7:0] addr_s;
  wire [7:0] ext_rd_s;

  opb_pin_sync #(.W(11)) u_sync_ctl (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin_in   ({address_latch_strobe, bus_read_write, strobe_a_input, bus_addr_high}),
    .sync_out ({as_s, rw_s, strobe_a_input_s, addr_s})
  );

  opb_pin_sync #(.W(8)) u_sync_rd (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin_in   (ext_read_data),
    .sync_out (ext_rd_s)
  );

  // ========================================================================
  // bus-cycle phase divider
  // quarter 0 starts at the E fall, quarter 1 at phase-two rise,
  // quarter 2 at the E rise, quarter 3 at phase-two fall
  reg  [1:0] phase_q;
  wire       ph2_rise_en;
  wire       ph2_fall_en;

  assign ph2_rise_en = (phase_q == `OPB_Q_ELOW_A);
  assign ph2_fall_en = (phase_q == `OPB_Q_EHIGH_A);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q     <= `OPB_Q_ELOW_A;
      bus_clock_e <= 1'b0;
    end else begin
      phase_q     <= phase_q + 2'h1;
      bus_clock_e <= (phase_q == `OPB_Q_ELOW_B) || (phase_q == `OPB_Q_EHIGH_A);
    end
  end

  // ========================================================================
  // control registers
  reg  [`OPB_PARALLEL_IO_CONTROL_W-1:0] parallel_io_control_q;
  reg                    expanded_mode_flag;
  wire                   strobe_polarity_bit;
  wire                   edge_select_bit;
  wire                   pulse_mode_bit;
  wire                   handshake_direction_bit;
  wire                   handshake_select_bit;

  assign strobe_polarity_bit     = parallel_io_control_q[`OPB_PARALLEL_IO_CONTROL_POL];
  assign edge_select_bit         = parallel_io_control_q[`OPB_PARALLEL_IO_CONTROL_EDGE];
  assign pulse_mode_bit          = parallel_io_control_q[`OPB_PARALLEL_IO_CONTROL_PLS];
  assign handshake_direction_bit = parallel_io_control_q[`OPB_PARALLEL_IO_CONTROL_DIR];
  assign handshake_select_bit    = parallel_io_control_q[`OPB_PARALLEL_IO_CONTROL_HANDSHAKE_SELECT_BIT];

  // ========================================================================
  // APB decode
  wire setup_ph;
  wire access_ph;
  wire hit_port;
  wire hit_latched;
  wire hit_parallel_io_control;
  wire hit_mode;
  wire hit_status;
  wire hit_any;
  wire wr_acc;
  wire rd_acc;

  assign setup_ph    = psel & ~penable;
  assign access_ph   = psel & penable;
  assign hit_port    = (paddr == `OPB_OFS_PORT);
  assign hit_latched = (paddr == `OPB_OFS_LATCHED);
  assign hit_parallel_io_control    = (paddr == `OPB_OFS_PARALLEL_IO_CONTROL);
  assign hit_mode    = (paddr == `OPB_OFS_MODE);
  assign hit_status  = (paddr == `OPB_OFS_STATUS);
  assign hit_any     = hit_port | hit_latched | hit_parallel_io_control | hit_mode | hit_status;
  assign wr_acc      = access_ph & pwrite & hit_any;
  assign rd_acc      = access_ph & ~pwrite & hit_any;

  // zero wait states: read data is captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = access_ph & ~hit_any;

  // in expanded mode the port address belongs to the external bus
  assign port_read_strobe = rd_acc & hit_port & ~expanded_mode_flag;

  wire port_wr_int;
  wire port_rd_int;
  wire latched_rd;
  wire latched_wr;
  wire parallel_io_control_wr;

  assign port_wr_int = wr_acc & hit_port & ~expanded_mode_flag;
  assign port_rd_int = port_read_strobe;
  assign latched_rd  = rd_acc & hit_latched;
  assign latched_wr  = wr_acc & hit_latched;
  assign parallel_io_control_wr     = wr_acc & hit_parallel_io_control;

  // ========================================================================
  // external access forwarding in expanded mode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_access_req   <= 1'b0;
      ext_access_write <= 1'b0;
      ext_write_data   <= `OPB_PINS_RST;
    end else begin
      ext_access_req <= access_ph & hit_port & expanded_mode_flag;
      if (access_ph & hit_port & expanded_mode_flag) begin
        ext_access_write <= pwrite;
        ext_write_data   <= pwdata[7:0];
      end
    end
  end

  // ========================================================================
  // register writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      parallel_io_control_q             <= `OPB_PARALLEL_IO_CONTROL_RST;
      expanded_mode_flag <= 1'b0;
    end else begin
      if (parallel_io_control_wr) begin
        parallel_io_control_q <= pwdata[`OPB_PARALLEL_IO_CONTROL_W-1:0];
      end
      if (wr_acc & hit_mode) begin
        expanded_mode_flag <= pwdata[`OPB_MODE_EXP];
      end
    end
  end

  // ========================================================================
  // port output path
  reg  [7:0] port_store_q;
  reg  [7:0] wr_data_q;
  reg        wr_pend_q;
  reg  [7:0] addr_hold_q;
  reg        rw_hold_q;
  wire       apply_wr;

  // a pending write waits one more phase-two fall if a port read is in progress
  assign apply_wr = wr_pend_q & ph2_fall_en & ~port_rd_int;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_store_q <= `OPB_PINS_RST;
      wr_data_q    <= `OPB_PINS_RST;
      wr_pend_q    <= 1'b0;
    end else begin
      if (port_wr_int) begin
        wr_data_q <= pwdata[7:0];
      end
      // a new write keeps the write pending; the previous data is still applied in that same cycle
      if (port_wr_int) begin
        wr_pend_q <= 1'b1;
      end else if (apply_wr) begin
        wr_pend_q <= 1'b0;
      end
      if (apply_wr) begin
        port_store_q <= wr_data_q;
      end
    end
  end

  // address and read/write storage: transparent while the latch strobe is high
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_hold_q <= `OPB_PINS_RST;
      rw_hold_q   <= 1'b1;
    end else if (as_s) begin
      addr_hold_q <= addr_s;
      rw_hold_q   <= rw_s;
    end
  end

  // ========================================================================
  // strobe sequencing
  reg        strobe_active_q;
  reg        start_pend_q;
  reg        end_pend_q;
  reg  [1:0] period_cnt_q;
  reg        strobe_a_input_prev_q;
  wire       pulsed;
  wire       interlocked;
  reg        start_event;
  wire       strobe_a_input_edge;

  assign pulsed      = ~handshake_select_bit | pulse_mode_bit;
  assign interlocked = ~pulsed;

  always @* begin
    case ({handshake_select_bit, handshake_direction_bit})
      2'b10:   start_event = latched_rd;
      2'b11:   start_event = latched_wr;
      default: start_event = port_wr_int;
    endcase
  end

  assign strobe_a_input_edge = edge_select_bit ? (strobe_a_input_s & ~strobe_a_input_prev_q) : (~strobe_a_input_s & strobe_a_input_prev_q);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_active_q <= 1'b0;
      start_pend_q    <= 1'b0;
      end_pend_q      <= 1'b0;
      period_cnt_q    <= 2'h0;
      strobe_a_input_prev_q     <= 1'b0;
    end else begin
      strobe_a_input_prev_q <= strobe_a_input_s;
      // requests raised in the same cycle as the edge are kept, not lost
      if (start_event) begin
        start_pend_q <= 1'b1;
      end else if (ph2_rise_en) begin
        start_pend_q <= 1'b0;
      end
      if ((strobe_active_q & interlocked & strobe_a_input_edge) |
          (strobe_active_q & parallel_io_control_wr & pwdata[`OPB_PARALLEL_IO_CONTROL_PLS] & pwdata[`OPB_PARALLEL_IO_CONTROL_HANDSHAKE_SELECT_BIT])) begin
        end_pend_q <= 1'b1;
      end else if (ph2_rise_en) begin
        end_pend_q <= 1'b0;
      end
      if (ph2_rise_en) begin
        if (start_pend_q) begin
          // a fresh start outranks any end due at the same edge
          strobe_active_q <= 1'b1;
          period_cnt_q    <= 2'h0;
        end else if (strobe_active_q) begin
          period_cnt_q <= period_cnt_q + 2'h1;
          if (end_pend_q) begin
            strobe_active_q <= 1'b0;
          end else if (pulsed && (period_cnt_q == `OPB_STROBE_B_OUTPUT_LAST)) begin
            strobe_active_q <= 1'b0;
          end
        end
      end
    end
  end

  // ========================================================================
  // pin drivers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_port_data <= `OPB_PINS_RST;
      strobe_b_output  <= 1'b1;
    end else begin
      // pins are always driven; only the data source changes with mode
      output_port_data <= expanded_mode_flag ? addr_hold_q : port_store_q;
      if (expanded_mode_flag) begin
        strobe_b_output <= rw_hold_q;
      end else begin
        strobe_b_output <= strobe_polarity_bit ? strobe_active_q : ~strobe_active_q;
      end
    end
  end

  // ========================================================================
  // read data, captured in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `OPB_DATA_RST;
    end else if (setup_ph & ~pwrite) begin
      prdata <= `OPB_DATA_RST;
      if (hit_port) begin
        // the driven state, not the pins; the external bus answers in expanded mode
        // the storage that feeds the pins: equals the pins through the access cycle, so no tear
        prdata[7:0] <= expanded_mode_flag ? ext_rd_s : port_store_q;
      end else if (hit_parallel_io_control) begin
        prdata[`OPB_PARALLEL_IO_CONTROL_W-1:0] <= parallel_io_control_q;
      end else if (hit_mode) begin
        prdata[`OPB_MODE_EXP] <= expanded_mode_flag;
      end else if (hit_status) begin
        prdata[`OPB_STAT_ACTIVE] <= strobe_active_q;
        prdata[`OPB_STAT_START]  <= start_pend_q;
        prdata[`OPB_STAT_WPEND]  <= wr_pend_q;
      end
    end
  end

endmodule

/* tb/opb_port_b_checker.sv */
// opb_port_b_checker.sv: concurrent checks on the ports of the output port block.
// assumes it is bound into opb_port_b and sees nothing but that module's ports.
`timescale 1ns/1ns

module opb_port_b_checker (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic [7:0]  output_port_data,
  input logic        strobe_b_output,
  input logic        strobe_a_input,
  input logic        address_latch_strobe,
  input logic [7:0]  bus_addr_high,
  input logic        bus_read_write,
  input logic [7:0]  ext_read_data,
  input logic        ext_access_req,
  input logic        ext_access_write,
  input logic [7:0]  ext_write_data,
  input logic        port_read_strobe,
  input logic        bus_clock_e
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================================
  // assertions
  AST_RESET_IDLE: assert property ($rose(presetn) |-> output_port_data == 8'h00 && strobe_b_output)
    else $error("port pins or strobe not idle after reset");
  AST_EXT_CAUSE: assert property (ext_access_req |-> $past(psel) && $past(penable) && $past(paddr) == 12'h000)
    else $error("external access without a port access");
  AST_EXT_DIR: assert property (ext_access_req |-> ext_access_write == $past(pwrite))
    else $error("external access direction wrong");
  AST_EXT_DATA: assert property (ext_access_req && ext_access_write |->
    {24'h00_0000, ext_write_data} == ($past(pwdata) & 32'h0000_00FF))
    else $error("external write data wrong");
  AST_RD_STROBE_CAUSE: assert property (port_read_strobe |-> psel && penable && !pwrite && paddr == 12'h000)
    else $error("port read strobe without a port read");
  AST_RD_STROBE_LOCAL: assert property (port_read_strobe |=> !ext_access_req)
    else $error("port read strobe on an external access");
  // a read must see the driven pins, and they may not move under it
  AST_READ_PINS: assert property (port_read_strobe |-> prdata == {24'h00_0000, output_port_data})
    else $error("port read differs from pins");
  AST_BUS_CLOCK: assert property ($rose(bus_clock_e) |=> bus_clock_e ##1 !bus_clock_e ##1 !bus_clock_e ##1 bus_clock_e)
    else $error("bus clock not four cycles");

  cover property (port_read_strobe);
  cover property (ext_access_req && ext_access_write);
  cover property ($fell(strobe_b_output));
endmodule

/* tb/opb_ext_model.sv */
// opb_ext_model.sv: far side of the output port block: bus address pins, strobe A and an emulated port.
// assumes the bench sets the wanted pin levels on the drv_ inputs.
`timescale 1ns/1ns

module opb_ext_model (
  input  logic       pclk,
  input  logic       presetn,
  input  logic       drv_as,
  input  logic [7:0] drv_addr,
  input  logic       drv_rw,
  input  logic       drv_strobe_a_input,
  input  logic       ext_access_req,
  input  logic       ext_access_write,
  input  logic [7:0] ext_write_data,
  output logic       address_latch_strobe = 1'b0,
  output logic [7:0] bus_addr_high = 8'h00,
  output logic       bus_read_write = 1'b0,
  output logic       strobe_a_input = 1'b0,
  output logic [7:0] ext_read_data
);
  logic [7:0] emul_q;

  // ==========================================================================
  // pins move just after the edge, never on it
  always @(posedge pclk) begin
    address_latch_strobe <= drv_as;
    bus_addr_high        <= drv_addr;
    bus_read_write       <= drv_rw;
    strobe_a_input       <= drv_strobe_a_input;
  end

  // ==========================================================================
  // outside logic standing in for the port while the chip runs expanded
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      emul_q <= 8'h00;
    end else if (ext_access_req && ext_access_write) begin
      emul_q <= ext_write_data;
    end
  end
  assign ext_read_data = emul_q;
endmodule

/* tb/opb_port_b_tb.sv */
// opb_port_b_tb.sv: self-checking bench for the output port block over APB.
// assumes the register map header and a 100 MHz pclk.
`timescale 1ns/1ns
`include "opb_port_b_map.vh"

module opb_port_b_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, strobe_b_output, strobe_a_input, address_latch_strobe, bus_read_write;
  logic        ext_access_req, ext_access_write, port_read_strobe, bus_clock_e;
  logic [7:0]  output_port_data, bus_addr_high, ext_read_data, ext_write_data;
  logic        drv_as = 1'b0, drv_rw = 1'b0, drv_strobe_a_input = 1'b0;
  logic [7:0]  drv_addr = 8'h00;
  int          num_errors = 0, compares = 0, w, k;
  // strobe mode table: control value, trigger address, direction, active level, width
  logic [7:0]  pio [4] = '{8'h01, 8'h14, 8'h1C, 8'h14};
  logic [11:0] tad [4] = '{`OPB_OFS_PORT, `OPB_OFS_LATCHED, `OPB_OFS_LATCHED, `OPB_OFS_PORT};
  logic        tw [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
  logic        tact [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
  int          texp [4] = '{8, 8, 8, 0};

  opb_port_b opb_port_b_inst (.*);
  opb_ext_model opb_ext_model_inst (.*);

  always #5 pclk = ~pclk;

  // ==========================================================================
  // tasks
  task automatic results(input bit hung);
    if (hung) num_errors++;
    $display("checks %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) results(1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // waits for the strobe pin to reach act, then counts cycles spent there
  task automatic sw(input logic act, output int width);
    int n;
    width = 0;
    for (n = 0; n < 16 && strobe_b_output !== act; n++) @(negedge pclk);
    while (strobe_b_output === act && width < 60) begin
      @(negedge pclk);
      width++;
    end
    if (width >= 60) results(1'b1);
  endtask

  task automatic hold_low();
    int n;
    for (n = 0; n < 16 && strobe_b_output !== 1'b0; n++) @(negedge pclk);
    repeat (20) @(negedge pclk);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("pins_reset", output_port_data, 8'h00);
    chk("strobe_reset", strobe_b_output, 1'b1);
    apb(1'b0, `OPB_OFS_PORT, 32'h0000_0000);
    chk("port_reset_read", rd, 32'h0000_0000);
    apb(1'b1, `OPB_OFS_PORT, 32'h0000_00A5);
    sw(1'b0, w);
    chk("simple_strobe_len", w, 8);
    for (k = 0; k < 12 && output_port_data !== 8'hA5; k++) @(negedge pclk);
    chk("pins_written", output_port_data, 8'hA5);
    apb(1'b0, `OPB_OFS_PORT, 32'h0000_0000);
    chk("port_readback", rd, 32'h0000_00A5);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk("unmapped_err", err, 1'b1);
    chk("unmapped_rd", rd, 32'h0000_0000);
    $display("test single_chip_port done");

    for (k = 0; k < 4; k++) begin
      apb(1'b1, `OPB_OFS_PARALLEL_IO_CONTROL, {24'h00_0000, pio[k]});
      apb(tw[k], tad[k], 32'h0000_003C);
      sw(tact[k], w);
      chk("mode_strobe_len", w, texp[k]);
    end
    $display("test strobe_modes done");

    // interlocked: held until a rising strobe A edge
    apb(1'b1, `OPB_OFS_PARALLEL_IO_CONTROL, 32'h0000_0012);
    apb(1'b0, `OPB_OFS_LATCHED, 32'h0000_0000);
    hold_low();
    chk("interlock_hold", strobe_b_output, 1'b0);
    @(posedge pclk);
    drv_strobe_a_input <= 1'b1;
    sw(1'b0, w);
    // pin register, sync and edge take 6 edges, then up to one bus cycle to the rise tick
    chk("interlock_end", w >= 9 && w <= 12, 1'b1);
    apb(1'b0, `OPB_OFS_LATCHED, 32'h0000_0000);
    hold_low();
    apb(1'b1, `OPB_OFS_PARALLEL_IO_CONTROL, 32'h0000_0016);
    sw(1'b0, w);
    chk("pulse_switch_end", w >= 3 && w <= 6, 1'b1);
    $display("test interlocked done");

    // address and read/write differ from what single-chip mode left on the pins
    apb(1'b1, `OPB_OFS_MODE, 32'h0000_0001);
    @(posedge pclk);
    drv_as   <= 1'b1;
    drv_addr <= 8'h96;
    drv_rw   <= 1'b0;
    repeat (8) @(negedge pclk);
    chk("exp_addr_pass", output_port_data, 8'h96);
    chk("exp_rw_pass", strobe_b_output, 1'b0);
    @(posedge pclk);
    drv_as <= 1'b0;
    repeat (8) @(posedge pclk);
    drv_addr <= 8'h69;
    drv_rw   <= 1'b1;
    repeat (8) @(negedge pclk);
    chk("exp_addr_hold", output_port_data, 8'h96);
    chk("exp_rw_hold", strobe_b_output, 1'b0);
    apb(1'b1, `OPB_OFS_PORT, 32'h0000_005A);
    repeat (8) @(negedge pclk);
    apb(1'b0, `OPB_OFS_PORT, 32'h0000_0000);
    chk("exp_port_read", rd, 32'h0000_005A);
    chk("exp_pins_kept", output_port_data, 8'h96);
    $display("test expanded done");

    @(posedge pclk);
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("pins_rereset", output_port_data, 8'h00);
    chk("strobe_rereset", strobe_b_output, 1'b1);
    $display("test second_reset done");
    results(1'b0);
  end
endmodule

bind opb_port_b opb_port_b_checker opb_port_b_checker_inst (.*);
